// File: design/clk_ratio_consts.svh
`ifndef CLK_RATIO_CONSTS_SVH
`define CLK_RATIO_CONSTS_SVH

// Register byte offsets
`define CR_REG_STATUS 8'h00
`define CR_REG_RATIO 8'h04
`define CR_REG_DDRDIV 8'h08

// Status register field positions
`define CR_ST_VALID 0
`define CR_ST_ERROR 1
`define CR_ST_SYNC 2
`define CR_ST_PCI_ASYNC 3
`define CR_ST_HALF 4
`define CR_ST_LOCK 5
`define CR_ST_PLAT_LSB 8
`define CR_ST_CORE_LSB 12
`define CR_ST_DDR_LSB 16

// Ratio register field positions
`define CR_RT_PLAT_LSB 0
`define CR_RT_CORE_LSB 8
`define CR_RT_DDR_LSB 16

// Divide control register field positions
`define CR_DV_HALF 0
`define CR_DV_LOCK 1

// Reset values
`define CR_RST_HALF 1'b0
`define CR_RST_WORD 32'h0000_0000

// Strap code meaning synchronous DDR mode
`define CR_DDR_SYNC_CODE 3'h7

// Timing: strap settle time after reset release, and clock rate
`define CR_STRAP_SETTLE_NS 100
`define CR_CLK_MHZ 100

`endif

// File: design/clk_ratio_pkg.sv
package clk_ratio_pkg;

  // Power-up sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } cr_state_t;

  // Whole state of the ratio block
  typedef struct packed {
    cr_state_t st;
    logic [7:0] cnt;
    logic [3:0] plat_code;
    logic [2:0] core_code;
    logic [2:0] ddr_code;
    logic pci_async;
    logic valid;
    logic [3:0] plat_mult;
    logic [3:0] core_halves;
    logic [3:0] ddr_mult;
    logic sync;
    logic err;
    logic half;
    logic lock;
    logic memclk;
    logic phase;
    logic ack;
    logic [31:0] rdata;
  } cr_regs_t;

endpackage

// File: design/strap_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for board strap levels
module strap_sync #(
  parameter int W = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  // Stage one feeds stage two only
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // Refuse an empty vector
  if (W < 1) begin : g_chk
    $error("strap_sync width must be at least one");
  end

  // Shift the pins through both stages
  always_comb begin
    next_s.s1 = D;
    next_s.s2 = s.s1;
  end

  // Constant reset, clocked
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign Q = s.s2;

endmodule

// File: design/clk_ratio_cfg.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "clk_ratio_consts.svh"
module clk_ratio_cfg #(
  parameter int STRAP_SETTLE_NS = `CR_STRAP_SETTLE_NS,
  parameter int CLK_MHZ = `CR_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic RST,
  // Board straps, sampled after reset release
  input wire logic [3:0] PLATFORM_RATIO_STRAP,
  input wire logic CORE_RATIO_STRAP_BIT0,
  input wire logic CORE_RATIO_STRAP_BIT1,
  input wire logic CORE_RATIO_STRAP_BIT2,
  input wire logic [1:0] TIMESTAMP_TRIGGER_PINS,
  input wire logic TIMESTAMP_CLOCK_PIN,
  input wire logic PCI_ASYNC_STRAP,
  // From the DDR controller, same clock
  input wire logic DDR_CTRL_INIT_DONE,
  // Wishbone classic slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Clock configuration results
  output logic CONFIG_VALID,
  output logic CONFIG_ERROR,
  output logic [3:0] PLATFORM_MULT,
  output logic [3:0] CORE_RATIO_HALVES,
  output logic [3:0] DDR_MULT,
  output logic DDR_SYNC_MODE,
  output logic MEM_CLK_FROM_DDR_PLL,
  output logic DDR_PLL_ENABLE,
  output logic DDR_HALF_RATE,
  output logic PCI_CLK_FROM_PCI_PIN,
  output logic [5:0] MEM_BUS_CLOCK
);

  // Settle time as whole cycles, rounded up
  localparam int SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Latest edge after release at which the result must show
  localparam int AST_VALID_MAX = SETTLE_CYC + 2;
  // Strap vector width through the synchroniser: 4 + 3 + 3 + 1 pins
  localparam int SW = 11;

  // Counter is eight bits, synchroniser needs two cycles
  if (SETTLE_CYC < 3 || SETTLE_CYC > 255) begin : g_chk
    $error("clk_ratio_cfg settle count out of range");
  end

  clk_ratio_pkg::cr_regs_t s;      // Registered state
  clk_ratio_pkg::cr_regs_t next_s; // Next state
  logic [SW-1:0] pins;             // Raw strap pins
  logic [SW-1:0] pins_q;           // Synchronised straps
  logic [3:0] plat_now;            // Synchronised platform code
  logic [2:0] core_now;            // Synchronised core code
  logic [2:0] ddr_now;             // Synchronised DDR code
  logic bus_req;                   // New bus request this cycle
  logic [31:0] status_word;        // Status read view
  logic [31:0] ratio_word;         // Ratio read view
  logic [31:0] div_word;           // Divide control read view

  // Platform code: first pin is the most significant bit
  function automatic logic [3:0] plat_decode(input logic [3:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      4'h3: r = 4'h3;
      4'h4: r = 4'h4;
      4'h5: r = 4'h5;
      4'h6: r = 4'h6;
      4'h8: r = 4'h8;
      4'h9: r = 4'h9;
      4'hA: r = 4'hA;
      4'hC: r = 4'hC;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Core ratio in halves, zero for the reserved code
  function automatic logic [3:0] core_decode(input logic [2:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      3'h0: r = 4'h8;
      3'h1: r = 4'h9;
      3'h3: r = 4'h3;
      3'h4: r = 4'h4;
      3'h5: r = 4'h5;
      3'h6: r = 4'h6;
      3'h7: r = 4'h7;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // DDR multiplier, zero for reserved and synchronous codes
  function automatic logic [3:0] ddr_decode(input logic [2:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      3'h0: r = 4'h3;
      3'h1: r = 4'h4;
      3'h2: r = 4'h6;
      3'h3: r = 4'h8;
      3'h4: r = 4'hA;
      3'h5: r = 4'hC;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Straps pass two flops before anything reads them
  assign pins = {PLATFORM_RATIO_STRAP, CORE_RATIO_STRAP_BIT0, CORE_RATIO_STRAP_BIT1,
                 CORE_RATIO_STRAP_BIT2, TIMESTAMP_TRIGGER_PINS[1],
                 TIMESTAMP_TRIGGER_PINS[0], TIMESTAMP_CLOCK_PIN, PCI_ASYNC_STRAP};

  strap_sync #(
    .W(SW)
  ) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D(pins),
    .Q(pins_q)
  );

  // Split the synchronised vector
  assign plat_now = pins_q[10:7];
  assign core_now = pins_q[6:4];
  assign ddr_now = pins_q[3:1];

  // Only a fresh request is served; ack drops the cycle after
  assign bus_req = CYC_I && STB_I && !s.ack;

  // Read views
  always_comb begin
    status_word = `CR_RST_WORD;
    status_word[`CR_ST_VALID] = s.valid;
    status_word[`CR_ST_ERROR] = s.err;
    status_word[`CR_ST_SYNC] = s.sync;
    status_word[`CR_ST_PCI_ASYNC] = s.pci_async;
    status_word[`CR_ST_HALF] = s.half;
    status_word[`CR_ST_LOCK] = s.lock;
    status_word[`CR_ST_PLAT_LSB +: 4] = s.plat_code;
    status_word[`CR_ST_CORE_LSB +: 3] = s.core_code;
    status_word[`CR_ST_DDR_LSB +: 3] = s.ddr_code;
    ratio_word = `CR_RST_WORD;
    ratio_word[`CR_RT_PLAT_LSB +: 4] = s.plat_mult;
    ratio_word[`CR_RT_CORE_LSB +: 4] = s.core_halves;
    ratio_word[`CR_RT_DDR_LSB +: 4] = s.ddr_mult;
    div_word = `CR_RST_WORD;
    div_word[`CR_DV_HALF] = s.half;
    div_word[`CR_DV_LOCK] = s.lock;
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    // Sequencer: wait for straps to settle, then latch once
    case (s.st)
      clk_ratio_pkg::ST_SETTLE: begin
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == 8'(SETTLE_CYC - 1)) begin
          next_s.st = clk_ratio_pkg::ST_RUN;
          next_s.plat_code = plat_now;
          next_s.core_code = core_now;
          next_s.ddr_code = ddr_now;
          next_s.pci_async = pins_q[0];
          next_s.plat_mult = plat_decode(plat_now);
          // Core ratio is against the one platform bus clock
          next_s.core_halves = core_decode(core_now);
          next_s.ddr_mult = ddr_decode(ddr_now);
          next_s.sync = (ddr_now == `CR_DDR_SYNC_CODE);
          // No default exists, so any reserved code is an error
          next_s.err = (plat_decode(plat_now) == 4'h0) ||
                       (core_decode(core_now) == 4'h0) ||
                       (ddr_now == 3'h6);
          next_s.valid = 1'b1;
        end
      end
      clk_ratio_pkg::ST_RUN: begin
        // Held until the next reset
        next_s.st = clk_ratio_pkg::ST_RUN;
      end
      default: begin
        // Illegal code, restart the power-up wait
        next_s.st = clk_ratio_pkg::ST_SETTLE;
        next_s.cnt = 8'h00;
        next_s.valid = 1'b0;
      end
    endcase

    // Divide setting freezes once the DDR controller is initialised
    next_s.lock = s.lock || DDR_CTRL_INIT_DONE;

    // Memory clock: only generated here in synchronous mode
    next_s.phase = 1'b0;
    next_s.memclk = 1'b0;
    if (s.valid && s.sync) begin
      next_s.phase = !s.phase;
      // Toggle each cycle gives half the platform rate
      if (!s.half || s.phase) begin
        next_s.memclk = !s.memclk;
      end else begin
        next_s.memclk = s.memclk;
      end
    end

    // Bus: answer every request after one cycle
    next_s.ack = bus_req;
    next_s.rdata = `CR_RST_WORD;
    if (bus_req) begin
      if (!WE_I) begin
        case (ADR_I)
          `CR_REG_STATUS: next_s.rdata = status_word;
          `CR_REG_RATIO: next_s.rdata = ratio_word;
          `CR_REG_DDRDIV: next_s.rdata = div_word;
          default: next_s.rdata = `CR_RST_WORD; // Unmapped reads zero
        endcase
      end else if (ADR_I == `CR_REG_DDRDIV && SEL_I[0] && !s.lock) begin
        next_s.half = DAT_I[`CR_DV_HALF];
      end
    end
  end

  // Register the state; reset takes constants only
  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
      s.st <= clk_ratio_pkg::ST_SETTLE;
      s.half <= `CR_RST_HALF;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign DAT_O = s.rdata;
  assign ACK_O = s.ack;
  assign CONFIG_VALID = s.valid;
  assign CONFIG_ERROR = s.err;
  assign PLATFORM_MULT = s.plat_mult;
  assign CORE_RATIO_HALVES = s.core_halves;
  assign DDR_MULT = s.ddr_mult;
  assign DDR_SYNC_MODE = s.valid && s.sync;
  // Async mode hands the memory clock to the DDR loop
  assign MEM_CLK_FROM_DDR_PLL = s.valid && !s.sync;
  // Loop and its reference are only needed in async mode
  assign DDR_PLL_ENABLE = s.valid && !s.sync;
  assign DDR_HALF_RATE = s.half;
  // PCI source follows the strapped mode
  assign PCI_CLK_FROM_PCI_PIN = s.valid && s.pci_async;
  // All six memory clock pins carry the same phase
  assign MEM_BUS_CLOCK = {6{s.memclk}};

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  AST_PLAT_RESERVED: assert property (
    CONFIG_VALID |-> ((PLATFORM_MULT == 4'h0) == !(s.plat_code inside
      {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC})))
    else $error("platform ratio reserved decode wrong");

  AST_PLAT_TWELVE: assert property (
    (CONFIG_VALID && s.plat_code == 4'hC) |-> PLATFORM_MULT == 4'hC)
    else $error("platform code 1100 not twelve");

  AST_LATCH_HOLD: assert property (
    CONFIG_VALID |=> CONFIG_VALID && $stable(PLATFORM_MULT) && $stable(CORE_RATIO_HALVES)
      && $stable(DDR_MULT))
    else $error("latched ratios changed after power-up");

  AST_VALID_TIME: assert property (
    $fell(RST) |-> !CONFIG_VALID ##[1:AST_VALID_MAX] CONFIG_VALID)
    else $error("straps not latched in time");

  AST_CORE_RESERVED: assert property (
    (CONFIG_VALID && s.core_code == 3'h2) |-> CORE_RATIO_HALVES == 4'h0 && CONFIG_ERROR)
    else $error("core reserved code not flagged");

  AST_CORE_NINE_HALVES: assert property (
    (CONFIG_VALID && s.core_code == 3'h1) |-> CORE_RATIO_HALVES == 4'h9)
    else $error("core code 001 not nine halves");

  AST_DDR_SYNC: assert property (
    (CONFIG_VALID && s.ddr_code == 3'h7) |-> DDR_SYNC_MODE && !MEM_CLK_FROM_DDR_PLL
      && DDR_MULT == 4'h0)
    else $error("ddr sync code misread");

  AST_MEMCLK_HALF: assert property (
    (DDR_SYNC_MODE && !DDR_HALF_RATE) |=> MEM_BUS_CLOCK[0] != $past(MEM_BUS_CLOCK[0]))
    else $error("memory clock not half platform");

  AST_MEMCLK_ASYNC: assert property (
    MEM_CLK_FROM_DDR_PLL |=> MEM_BUS_CLOCK == 6'h00 && DDR_PLL_ENABLE)
    else $error("memory clock driven in async mode");

  AST_PCI_SOURCE: assert property (
    CONFIG_VALID |-> PCI_CLK_FROM_PCI_PIN == s.pci_async)
    else $error("pci clock source wrong");

  AST_DIV_LOCKED: assert property (
    s.lock |=> $stable(DDR_HALF_RATE) && s.lock)
    else $error("divide changed after ddr init");

  AST_ERR_FLAG: assert property (
    CONFIG_VALID |-> CONFIG_ERROR == ((PLATFORM_MULT == 4'h0) ||
      (CORE_RATIO_HALVES == 4'h0) || (s.ddr_code == 3'h6)))
    else $error("configuration error flag wrong");

  AST_ACK_ONE: assert property (
    ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");

  COV_SYNC: cover property (DDR_SYNC_MODE ##1 MEM_BUS_CLOCK[0]);
  COV_ASYNC: cover property (CONFIG_VALID && MEM_CLK_FROM_DDR_PLL);
  COV_ERROR: cover property (CONFIG_VALID && CONFIG_ERROR);
  COV_DIV_WRITE: cover property (!DDR_HALF_RATE ##1 DDR_HALF_RATE);

endmodule

// File: tb/strap_board_model.sv
`timescale 1ns/1ps
// Board side: strap resistors that hold each pin at a fixed level
module strap_board_model (
  input wire logic [3:0] plat_code,
  input wire logic [2:0] core_code,
  input wire logic [2:0] ddr_code,
  input wire logic pci_async,
  output logic [3:0] plat_pins,
  output logic core_b0,
  output logic core_b1,
  output logic core_b2,
  output logic [1:0] trig_pins,
  output logic ts_clk_pin,
  output logic pci_async_pin
);
  // Every platform strap bit pulled hard, none left floating
  assign plat_pins = plat_code;
  // Core code, first pin carries the msb
  assign {core_b0, core_b1, core_b2} = core_code;
  // DDR code; a non-sync code assumes the DDR reference is fitted
  assign {trig_pins[1], trig_pins[0], ts_clk_pin} = ddr_code;
  // Board fits a separate PCI clock when it picks this level
  assign pci_async_pin = pci_async;
endmodule

// File: tb/reset_strap_clock_ratio_select_tb.sv
`timescale 1ns/1ps
module reset_strap_clock_ratio_select_tb;
  logic clk, rst, cyc, stb, we, init_done, pci_s, pci_pin, pci_a;
  logic [7:0] adr;
  logic [3:0] sel, plat_s, plat_p, pm, ch, dm;
  logic [31:0] dat_w, dat_r, rd;
  logic ack, valid, err, sync, pll_mem, pll_en, half;
  logic [2:0] core_s, ddr_s;
  logic cb0, cb1, cb2, tclk;
  logic [1:0] trig;
  logic [5:0] mck;
  int n_errors, num_checks;

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  strap_board_model board (.plat_code(plat_s), .core_code(core_s), .ddr_code(ddr_s),
    .pci_async(pci_s), .plat_pins(plat_p), .core_b0(cb0), .core_b1(cb1), .core_b2(cb2),
    .trig_pins(trig), .ts_clk_pin(tclk), .pci_async_pin(pci_a));

  clk_ratio_cfg dut (.CLK(clk), .RST(rst), .PLATFORM_RATIO_STRAP(plat_p),
    .CORE_RATIO_STRAP_BIT0(cb0), .CORE_RATIO_STRAP_BIT1(cb1), .CORE_RATIO_STRAP_BIT2(cb2),
    .TIMESTAMP_TRIGGER_PINS(trig), .TIMESTAMP_CLOCK_PIN(tclk), .PCI_ASYNC_STRAP(pci_a),
    .DDR_CTRL_INIT_DONE(init_done), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .CONFIG_VALID(valid),
    .CONFIG_ERROR(err), .PLATFORM_MULT(pm), .CORE_RATIO_HALVES(ch), .DDR_MULT(dm),
    .DDR_SYNC_MODE(sync), .MEM_CLK_FROM_DDR_PLL(pll_mem), .DDR_PLL_ENABLE(pll_en),
    .DDR_HALF_RATE(half), .PCI_CLK_FROM_PCI_PIN(pci_pin), .MEM_BUS_CLOCK(mck));

  // Expected platform multiplier, zero for reserved codes
  function automatic logic [3:0] plat_exp(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: plat_exp = c;
      default: plat_exp = 4'h0;
    endcase
  endfunction

  // Core ratio in halves; 010 is the only reserved code
  function automatic logic [3:0] core_exp(input logic [2:0] c);
    case (c)
      3'h0: core_exp = 4'h8;
      3'h1: core_exp = 4'h9;
      3'h2: core_exp = 4'h0;
      default: core_exp = {1'b0, c};
    endcase
  endfunction

  // DDR multiplier; reserved and sync codes give zero
  function automatic logic [3:0] ddr_exp(input logic [2:0] c);
    case (c)
      3'h0: ddr_exp = 4'h3;
      3'h1: ddr_exp = 4'h4;
      3'h2: ddr_exp = 4'h6;
      3'h3: ddr_exp = 4'h8;
      3'h4: ddr_exp = 4'ha;
      3'h5: ddr_exp = 4'hc;
      default: ddr_exp = 4'h0;
    endcase
  endfunction

  // Any reserved field marks the whole configuration bad
  function automatic logic err_exp(input logic [3:0] p, input logic [2:0] c, input logic [2:0] d);
    err_exp = (plat_exp(p) == 4'h0) || (c == 3'h2) || (d == 3'h6);
  endfunction

  // Status word as software should see it once latched
  function automatic logic [31:0] stat_exp(input logic [3:0] p, input logic [2:0] c,
    input logic [2:0] d, input logic a, input logic h, input logic l);
    stat_exp = {13'h0, d, 1'b0, c, p, 2'b00, l, h, a, d == 3'h7, err_exp(p, c, d), 1'b1};
  endfunction

  task complete_run;
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Single comparison, all values widened to a word
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic Wishbone cycle; waits for ack under a bound
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k == 20) begin
      n_errors++;
      complete_run();
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hf, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Hold reset for 16 cycles, release on an edge
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Memory clock: equal bits, expected number of changes over four cycles
  task mck_chk(input int nch);
    logic [5:0] prev;
    int n;
    n = 0;
    @(posedge clk);
    #1 prev = mck;
    repeat (4) begin
      @(posedge clk);
      #1 chk(32'(mck), nch == 0 ? 32'h0000_0000 : 32'({6{mck[0]}}));
      if (mck !== prev) n++;
      prev = mck;
    end
    chk(32'(n), 32'(nch));
  endtask

  initial begin
    logic [3:0] p;
    logic [2:0] c, d;
    logic a;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    init_done = 1'b0;
    {plat_s, core_s, ddr_s, pci_s} = 11'h000;
    n_errors = 0;
    num_checks = 0;
    // Every platform, core and DDR code, each latched across a fresh reset
    for (int i = 0; i < 16; i++) begin
      p = 4'(i);
      c = 3'(i);
      d = 3'(i + 5);
      a = p[0];
      @(posedge clk);
      plat_s <= p;
      core_s <= c;
      ddr_s <= d;
      pci_s <= a;
      do_reset();
      repeat (9) @(posedge clk);
      #1 chk(32'(valid), 32'h0000_0000);
      @(posedge clk);
      #1 chk(32'(valid), 32'h0000_0001);
      chk(32'(pm), 32'(plat_exp(p)));
      chk(32'(ch), 32'(core_exp(c)));
      chk(32'(dm), 32'(ddr_exp(d)));
      chk(32'(err), 32'(err_exp(p, c, d)));
      chk(32'(sync), 32'(d == 3'h7));
      chk(32'({pll_mem, pll_en}), d == 3'h7 ? 32'h0000_0000 : 32'h0000_0003);
      chk(32'(pci_pin), 32'(a));
      rdchk(8'h00, stat_exp(p, c, d, a, 1'b0, 1'b0));
      rdchk(8'h04, {12'h0, ddr_exp(d), 4'h0, core_exp(c), 4'h0, plat_exp(p)});
      mck_chk(d == 3'h7 ? 4 : 0);
      // Straps moved after latching must not disturb the latched ratios or sync mode
      @(posedge clk);
      plat_s <= ~p;
      core_s <= ~c;
      ddr_s <= ~d;
      repeat (4) @(posedge clk);
      #1 chk(32'({pm, ch, dm, sync}),
        32'({plat_exp(p), core_exp(c), ddr_exp(d), d == 3'h7}));
    end
    // Sync mode with divide control and its lock
    @(posedge clk);
    plat_s <= 4'h4;
    core_s <= 3'h0;
    ddr_s <= 3'h7;
    pci_s <= 1'b0;
    do_reset();
    repeat (12) @(posedge clk);
    wb(1'b1, 8'h08, 4'he, 32'h0000_0001);
    rdchk(8'h08, 32'h0000_0000);
    wb(1'b1, 8'h08, 4'h1, 32'h0000_0001);
    chk(32'(half), 32'h0000_0001);
    mck_chk(2);
    wb(1'b1, 8'h00, 4'hf, 32'hffff_ffff);
    rdchk(8'h00, stat_exp(4'h4, 3'h0, 3'h7, 1'b0, 1'b1, 1'b0));
    rdchk(8'h0c, 32'h0000_0000);
    @(posedge clk);
    init_done <= 1'b1;
    wb(1'b1, 8'h08, 4'h1, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_0003);
    chk(32'(half), 32'h0000_0001);
    init_done <= 1'b0;
    complete_run();
  end
endmodule
